/* common/sstp_pkg.sv */
// Shared constants and types of the memory scan test port
package sstp_pkg;

    // Instruction register width and codes
    localparam int          IR_W          = 3;
    localparam logic [2:0]  INS_EXTEST    = 3'h0;
    localparam logic [2:0]  INS_IDCODE    = 3'h1;
    localparam logic [2:0]  INS_SAMPLE_Z  = 3'h2;
    localparam logic [2:0]  INS_RSVD_A    = 3'h3; // reserved_vendor_code
    localparam logic [2:0]  INS_SAMPLE    = 3'h4;
    localparam logic [2:0]  INS_RSVD_B    = 3'h5; // reserved_vendor_code
    localparam logic [2:0]  INS_RSVD_C    = 3'h6; // reserved_vendor_code
    localparam logic [2:0]  INS_BYPASS    = 3'h7;
    // Fixed pattern loaded into the instruction shifter at capture
    localparam logic [2:0]  IR_CAPTURE    = 3'h1;
    // Instruction taken at power-up and in test-logic-reset
    localparam logic [2:0]  IR_RST        = INS_IDCODE;

    // Identification register layout (chip_identification)
    localparam int          ID_W          = 32;
    localparam int          ID_REV_MSB    = 31;
    localparam int          ID_REV_LSB    = 29;
    localparam int          ID_CFG_MSB    = 28;
    localparam int          ID_CFG_LSB    = 12;
    localparam int          ID_MAKER_MSB  = 11;
    localparam int          ID_MAKER_LSB  = 1;
    localparam int          ID_START_BIT  = 0;
    // Part configuration fields, absolute bit positions
    localparam int          CFG_TERM_HI   = 27;
    localparam int          CFG_DEN_MSB   = 26;
    localparam int          CFG_DEN_LSB   = 24;
    localparam int          CFG_WID_MSB   = 22;
    localparam int          CFG_WID_LSB   = 21;
    localparam int          CFG_ONE_BIT   = 19;
    localparam int          CFG_ENH       = 18;
    localparam int          CFG_PORT      = 17;
    localparam int          CFG_RL        = 16;
    localparam int          CFG_BURST     = 15;
    localparam int          CFG_TERM_LO   = 14;
    localparam int          CFG_SIO       = 13;
    // density_field and width_field codes
    localparam logic [2:0]  DEN_18MB      = 3'h1;
    localparam logic [2:0]  DEN_36MB      = 3'h2;
    localparam logic [2:0]  DEN_72MB      = 3'h3;
    localparam logic [1:0]  WID_X36       = 2'h3;
    localparam logic [1:0]  WID_X18       = 2'h2;
    // read_latency in half cycles that sets the latency flag
    localparam int          RL_FLAG_HALF  = 5;

    // Boundary chain
    localparam int          BS_CELLS      = 109;
    localparam int          BS_PINS       = 108;
    localparam int          BS_OE_CELL    = 108; // index of cell 109
    localparam logic        BS_OE_RST     = 1'b0;

    // Timing
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          TDO_VALID_NS  = 10;
    localparam int          TDO_VALID_CYC =
        (TDO_VALID_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (TDO_VALID_NS / CLK_PERIOD_NS);

    // Data register selection
    typedef enum logic [1:0] {
        SEL_BOUNDARY = 2'h0,
        SEL_IDENT    = 2'h1,
        SEL_BYPASS   = 2'h2
    } sstp_dr_sel_t;

    // Sixteen tap controller states, one-hot
    typedef enum logic [15:0] {
        ST_TLR    = 16'h0001,
        ST_RTI    = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR  = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PA_DR  = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR  = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PA_IR  = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } sstp_tap_state_t;

endpackage

/* verilog/sstp_sync.sv */
`timescale 1ns/1ns
// Three-stage input synchroniser with an agreement filter per bit
module sstp_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out
);

    // Width must be usable
    if (WIDTH < 1) begin : g_chk
        $error("sstp_sync: WIDTH must be at least 1");
    end

    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        logic s1_r;     // First stage, read only by the second
        logic s2_r;     // Second stage
        logic s3_r;     // Third stage
        logic lvl_r;    // Filtered level
        logic lvl_nxt;  // Next filtered level

        // Level moves only once second and third stage agree
        always_comb begin
            lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
        end

        // Register the chain and the filtered level
        always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                s1_r  <= 1'b0;
                s2_r  <= 1'b0;
                s3_r  <= 1'b0;
                lvl_r <= 1'b0;
            end else begin
                s1_r  <= async_in[i];
                s2_r  <= s1_r;
                s3_r  <= s2_r;
                lvl_r <= lvl_nxt;
            end
        end

        assign level_out[i] = lvl_r;
    end

endmodule

/* verilog/sstp_top.sv */
`timescale 1ns/1ns
// Behaviour
// RQ1: Decode instruction; route boundary, identification or bypass
// RQ2: Controller never loads the three reserved codes; the code loads them on update and they select bypass
// RQ3: 32-bit identification: revision, configuration, maker, one
// RQ4: Density field 001, 010, 011 by size
// RQ5: Width field 11 for x36, 10 x18
// RQ6: Enhanced flag and port-style flag per variant
// RQ7: Latency flag one only for 2.5 cycles
// RQ8: Burst flag one for four, zero two
// RQ9: Separate-pins flag one, shared pins zero
// RQ10: Termination flag one when option present
// RQ11: 109 cells; cell 109 internal, serial-loaded
// RQ12: Unconnected cells are don't-care captures
// RQ13: Test output changes after falling test clock
// RQ14: Under extest cell 109 enables data drivers
// RQ15: Reset state selects identification instruction
// RQ16: Sample-Z keeps data bus in high impedance
// RQ17: Single bypass bit cleared on capture
// RQ18: Standard sixteen-state controller, sampled on rise
module sstp_top #(
    parameter int           DENSITY_MB   = 36,
    parameter int           DATA_WIDTH   = 36,
    parameter bit           ENHANCED     = 1'b1,
    parameter bit           FOUR_WORD    = 1'b0,
    parameter int           RL_HALF      = 4,
    parameter int           BURST_LEN    = 2,
    parameter bit           SEPARATE_IO  = 1'b0,
    parameter bit           ODT_PRESENT  = 1'b0,
    parameter logic [2:0]   REVISION     = 3'h1,   // Arbitrary value
    parameter logic [10:0]  MAKER_CODE   = 11'h2A5, // Arbitrary value
    parameter logic [107:0] NC_CELL_MASK = 108'h0
) (
    input  wire logic          sys_clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          tck_in,        // Test clock pin
    input  wire logic          tms_in,        // Mode select pin
    input  wire logic          tdi_in,        // Serial data in pin
    input  wire logic [107:0]  bs_pins_in,    // Pin ring, cells 1..108
    output logic               tdo_out,       // Serial data out
    output logic               tdo_oe_n_out,  // Low while tdo driven
    output logic [108:0]       bs_update_out, // Boundary update latches
    output logic               dq_oe_n_out,   // Low lets data drivers run
    output logic               extest_out,    // Extest is current
    output logic [2:0]         instr_out      // Current instruction
);

    // Parameter screening
    if (!(DENSITY_MB == 18 || DENSITY_MB == 36 || DENSITY_MB == 72)
        || !(DATA_WIDTH == 18 || DATA_WIDTH == 36)
        || !(BURST_LEN == 2 || BURST_LEN == 4)
        || RL_HALF < 1) begin : g_chk
        $error("sstp_top: unsupported part parameters");
    end

    // Density and width codes
    localparam logic [2:0] DEN_CODE =
        (DENSITY_MB == 18) ? sstp_pkg::DEN_18MB :
        (DENSITY_MB == 36) ? sstp_pkg::DEN_36MB : sstp_pkg::DEN_72MB;
    localparam logic [1:0] WID_CODE =
        (DATA_WIDTH == 36) ? sstp_pkg::WID_X36 : sstp_pkg::WID_X18;

    // Hardwired identification word
    function automatic logic [31:0] id_word();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[sstp_pkg::ID_REV_MSB:sstp_pkg::ID_REV_LSB] = REVISION;
        w[sstp_pkg::ID_MAKER_MSB:sstp_pkg::ID_MAKER_LSB] = MAKER_CODE;
        w[sstp_pkg::ID_START_BIT] = 1'b1;                   // [RQ3]
        w[sstp_pkg::CFG_DEN_MSB:sstp_pkg::CFG_DEN_LSB] = DEN_CODE; // [RQ4]
        w[sstp_pkg::CFG_WID_MSB:sstp_pkg::CFG_WID_LSB] = WID_CODE; // [RQ5]
        w[sstp_pkg::CFG_ONE_BIT] = 1'b1;
        w[sstp_pkg::CFG_ENH]     = ENHANCED;                // [RQ6]
        w[sstp_pkg::CFG_PORT]    = FOUR_WORD;               // [RQ6]
        w[sstp_pkg::CFG_RL]      = RL_HALF == sstp_pkg::RL_FLAG_HALF; // [RQ7]
        w[sstp_pkg::CFG_BURST]   = (BURST_LEN == 4);        // [RQ8]
        w[sstp_pkg::CFG_SIO]     = SEPARATE_IO;             // [RQ9]
        w[sstp_pkg::CFG_TERM_HI] = ODT_PRESENT;             // [RQ10]
        w[sstp_pkg::CFG_TERM_LO] = ODT_PRESENT;             // [RQ10]
        return w;
    endfunction

    localparam logic [31:0] ID_VALUE = id_word();

    // Data register chosen by an instruction
    function automatic sstp_pkg::sstp_dr_sel_t dr_sel(logic [2:0] ins);
        case (ins)
            sstp_pkg::INS_EXTEST,
            sstp_pkg::INS_SAMPLE_Z,
            sstp_pkg::INS_SAMPLE:   dr_sel = sstp_pkg::SEL_BOUNDARY;
            sstp_pkg::INS_IDCODE:   dr_sel = sstp_pkg::SEL_IDENT;
            default:                dr_sel = sstp_pkg::SEL_BYPASS;
        endcase
    endfunction

    // Standard controller transition on a test clock rise
    function automatic sstp_pkg::sstp_tap_state_t tap_next(
        sstp_pkg::sstp_tap_state_t st, logic tms);
        case (st)
            sstp_pkg::ST_TLR:    tap_next = tms ? sstp_pkg::ST_TLR
                                                : sstp_pkg::ST_RTI;
            sstp_pkg::ST_RTI:    tap_next = tms ? sstp_pkg::ST_SEL_DR
                                                : sstp_pkg::ST_RTI;
            sstp_pkg::ST_SEL_DR: tap_next = tms ? sstp_pkg::ST_SEL_IR
                                                : sstp_pkg::ST_CAP_DR;
            sstp_pkg::ST_CAP_DR: tap_next = tms ? sstp_pkg::ST_EX1_DR
                                                : sstp_pkg::ST_SH_DR;
            sstp_pkg::ST_SH_DR:  tap_next = tms ? sstp_pkg::ST_EX1_DR
                                                : sstp_pkg::ST_SH_DR;
            sstp_pkg::ST_EX1_DR: tap_next = tms ? sstp_pkg::ST_UPD_DR
                                                : sstp_pkg::ST_PA_DR;
            sstp_pkg::ST_PA_DR:  tap_next = tms ? sstp_pkg::ST_EX2_DR
                                                : sstp_pkg::ST_PA_DR;
            sstp_pkg::ST_EX2_DR: tap_next = tms ? sstp_pkg::ST_UPD_DR
                                                : sstp_pkg::ST_SH_DR;
            sstp_pkg::ST_UPD_DR: tap_next = tms ? sstp_pkg::ST_SEL_DR
                                                : sstp_pkg::ST_RTI;
            sstp_pkg::ST_SEL_IR: tap_next = tms ? sstp_pkg::ST_TLR
                                                : sstp_pkg::ST_CAP_IR;
            sstp_pkg::ST_CAP_IR: tap_next = tms ? sstp_pkg::ST_EX1_IR
                                                : sstp_pkg::ST_SH_IR;
            sstp_pkg::ST_SH_IR:  tap_next = tms ? sstp_pkg::ST_EX1_IR
                                                : sstp_pkg::ST_SH_IR;
            sstp_pkg::ST_EX1_IR: tap_next = tms ? sstp_pkg::ST_UPD_IR
                                                : sstp_pkg::ST_PA_IR;
            sstp_pkg::ST_PA_IR:  tap_next = tms ? sstp_pkg::ST_EX2_IR
                                                : sstp_pkg::ST_PA_IR;
            sstp_pkg::ST_EX2_IR: tap_next = tms ? sstp_pkg::ST_UPD_IR
                                                : sstp_pkg::ST_SH_IR;
            sstp_pkg::ST_UPD_IR: tap_next = tms ? sstp_pkg::ST_SEL_DR
                                                : sstp_pkg::ST_RTI;
            default:             tap_next = sstp_pkg::ST_TLR;
        endcase
    endfunction

    // Filtered pin levels
    logic [2:0]                 pin_lvl;      // {tdi, tms, tck}
    logic                       tck_prev_r;   // Test clock one cycle ago
    logic                       tck_rise;     // Rising test clock seen
    logic                       tck_fall;     // Falling test clock seen
    // Controller and shifters
    sstp_pkg::sstp_tap_state_t  state_r, state_nxt;
    logic [2:0]                 ir_sr_r, ir_sr_nxt;   // Instruction shifter
    logic [2:0]                 ir_cur_r, ir_cur_nxt; // Current instruction
    logic [108:0]               bs_sr_r, bs_sr_nxt;   // Boundary shifter
    logic [108:0]               bs_upd_r, bs_upd_nxt; // Boundary latches
    logic [31:0]                id_sr_r, id_sr_nxt;   // Identification
    logic                       byp_r, byp_nxt;       // Bypass bit
    logic                       tdo_r, tdo_nxt;
    logic                       tdo_oe_n_r, tdo_oe_n_nxt;
    logic                       dq_oe_n_r, dq_oe_n_nxt;
    logic                       extest_r, extest_nxt; // Extest is current
    sstp_pkg::sstp_dr_sel_t     sel;                  // Chosen data reg

    // Pin synchroniser for clock, mode select and data in
    sstp_sync #(
        .WIDTH      (3)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   ({tdi_in, tms_in, tck_in}),
        .level_out  (pin_lvl)
    );

    // Edge detection on the filtered test clock
    assign tck_rise = pin_lvl[0] & ~tck_prev_r;
    assign tck_fall = ~pin_lvl[0] & tck_prev_r;
    assign sel      = dr_sel(ir_cur_r);                      // [RQ1]

    // Next values of the controller, shifters and pin drivers
    always_comb begin
        state_nxt    = state_r;
        ir_sr_nxt    = ir_sr_r;
        ir_cur_nxt   = ir_cur_r;
        bs_sr_nxt    = bs_sr_r;
        bs_upd_nxt   = bs_upd_r;
        id_sr_nxt    = id_sr_r;
        byp_nxt      = byp_r;
        tdo_nxt      = tdo_r;
        tdo_oe_n_nxt = tdo_oe_n_r;
        // Rising test clock: move and capture or shift
        if (tck_rise) begin
            state_nxt = tap_next(state_r, pin_lvl[1]);       // [RQ18]
            case (state_r)
                sstp_pkg::ST_CAP_DR: begin
                    // Masked cells capture zero so nothing uses them
                    bs_sr_nxt = {bs_upd_r[sstp_pkg::BS_OE_CELL],
                                 bs_pins_in & ~NC_CELL_MASK}; // [RQ12]
                    id_sr_nxt = ID_VALUE;                    // [RQ3]
                    byp_nxt   = 1'b0;                        // [RQ17]
                end
                sstp_pkg::ST_SH_DR: begin
                    // Only the chosen register moves
                    case (sel)
                        sstp_pkg::SEL_BOUNDARY:
                            bs_sr_nxt = {pin_lvl[2], bs_sr_r[108:1]};
                        sstp_pkg::SEL_IDENT:
                            id_sr_nxt = {pin_lvl[2], id_sr_r[31:1]};
                        default: byp_nxt = pin_lvl[2];
                    endcase
                end
                sstp_pkg::ST_CAP_IR: ir_sr_nxt = sstp_pkg::IR_CAPTURE;
                sstp_pkg::ST_SH_IR:  ir_sr_nxt = {pin_lvl[2], ir_sr_r[2:1]};
                default: ;
            endcase
        end
        // Falling test clock: update latches and present tdo
        if (tck_fall) begin
            if (state_r == sstp_pkg::ST_UPD_IR) begin
                ir_cur_nxt = ir_sr_r;
            end
            if (state_r == sstp_pkg::ST_UPD_DR
                && sel == sstp_pkg::SEL_BOUNDARY) begin
                bs_upd_nxt = bs_sr_r;                        // [RQ11]
            end
            if (state_r == sstp_pkg::ST_SH_DR) begin
                tdo_oe_n_nxt = 1'b0;
                case (sel)                                   // [RQ1]
                    sstp_pkg::SEL_BOUNDARY: tdo_nxt = bs_sr_r[0];
                    sstp_pkg::SEL_IDENT:    tdo_nxt = id_sr_r[0];
                    default:                tdo_nxt = byp_r;
                endcase
            end else if (state_r == sstp_pkg::ST_SH_IR) begin
                tdo_oe_n_nxt = 1'b0;
                tdo_nxt      = ir_sr_r[0];
            end else begin
                tdo_oe_n_nxt = 1'b1;                         // [RQ13]
            end
        end
        // Reset state forces identification and preset output cell
        if (state_r == sstp_pkg::ST_TLR) begin
            ir_cur_nxt = sstp_pkg::IR_RST;                   // [RQ15]
            bs_upd_nxt[sstp_pkg::BS_OE_CELL] = sstp_pkg::BS_OE_RST;
        end
        // Data driver control
        case (ir_cur_r)
            sstp_pkg::INS_EXTEST:
                dq_oe_n_nxt = ~bs_upd_r[sstp_pkg::BS_OE_CELL]; // [RQ14]
            sstp_pkg::INS_SAMPLE_Z: dq_oe_n_nxt = 1'b1;     // [RQ16]
            default:                dq_oe_n_nxt = 1'b0;
        endcase
        extest_nxt = (ir_cur_nxt == sstp_pkg::INS_EXTEST); // Tracks instr
    end

    // Register all state
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tck_prev_r <= 1'b0;
            state_r    <= sstp_pkg::ST_TLR;
            ir_sr_r    <= sstp_pkg::IR_CAPTURE;
            ir_cur_r   <= sstp_pkg::IR_RST;
            bs_sr_r    <= 109'h0;
            bs_upd_r   <= 109'h0;
            id_sr_r    <= 32'h0000_0000;
            byp_r      <= 1'b0;
            tdo_r      <= 1'b0;
            tdo_oe_n_r <= 1'b1;
            dq_oe_n_r  <= 1'b0;
            extest_r   <= 1'b0;
        end else begin
            tck_prev_r <= pin_lvl[0];
            state_r    <= state_nxt;
            ir_sr_r    <= ir_sr_nxt;
            ir_cur_r   <= ir_cur_nxt;
            bs_sr_r    <= bs_sr_nxt;
            bs_upd_r   <= bs_upd_nxt;
            id_sr_r    <= id_sr_nxt;
            byp_r      <= byp_nxt;
            tdo_r      <= tdo_nxt;
            tdo_oe_n_r <= tdo_oe_n_nxt;
            dq_oe_n_r  <= dq_oe_n_nxt;
            extest_r   <= extest_nxt;
        end
    end

    // Outputs straight from flops
    assign tdo_out       = tdo_r;
    assign tdo_oe_n_out  = tdo_oe_n_r;
    assign bs_update_out = bs_upd_r;
    assign dq_oe_n_out   = dq_oe_n_r;
    assign instr_out     = ir_cur_r;
    assign extest_out    = extest_r;

    // Checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    id_route_a: assert property (tck_fall && state_r == sstp_pkg::ST_SH_DR
        && ir_cur_r == sstp_pkg::INS_IDCODE
        |=> tdo_out == $past(id_sr_r[0]) && !tdo_oe_n_out) // [RQ1]
        else $error("identification bit not on tdo");
    id_capture_a: assert property (tck_rise
        && state_r == sstp_pkg::ST_CAP_DR
        |=> id_sr_r[0] && id_sr_r[31:29] == REVISION) // [RQ3]
        else $error("identification capture wrong");
    id_density_a: assert property (tck_rise
        && state_r == sstp_pkg::ST_CAP_DR
        |=> id_sr_r[26:24] == (DENSITY_MB == 72 ? 3'h3 :
            DENSITY_MB == 36 ? 3'h2 : 3'h1)) // [RQ4]
        else $error("density field wrong");
    id_width_a: assert property (tck_rise && state_r == sstp_pkg::ST_CAP_DR
        |=> id_sr_r[22:21] == (DATA_WIDTH == 36 ? 2'h3 : 2'h2)) // [RQ5]
        else $error("width field wrong");
    id_flags_a: assert property (tck_rise && state_r == sstp_pkg::ST_CAP_DR
        |=> id_sr_r[18:13] == {ENHANCED, FOUR_WORD, RL_HALF == 5,
            BURST_LEN == 4, ODT_PRESENT, SEPARATE_IO}) // [RQ6] [RQ8]
        else $error("configuration flags wrong");
    nc_cells_a: assert property (tck_rise && state_r == sstp_pkg::ST_CAP_DR
        |=> (bs_sr_r[107:0] & NC_CELL_MASK) == 108'h0) // [RQ12]
        else $error("unconnected cell captured a value");
    tdo_fall_a: assert property ($changed(tdo_out)
        |-> $past(tck_fall)) // [RQ13]
        else $error("tdo moved without falling test clock");
    extest_oe_a: assert property (ir_cur_r == sstp_pkg::INS_EXTEST
        |=> dq_oe_n_out == !$past(bs_upd_r[108])) // [RQ14]
        else $error("extest driver control wrong");
    tlr_ident_a: assert property (state_r == sstp_pkg::ST_TLR
        |=> ir_cur_r == sstp_pkg::INS_IDCODE && !bs_upd_r[108]) // [RQ15]
        else $error("reset state did not select identification");
    samplez_hiz_a: assert property (ir_cur_r == sstp_pkg::INS_SAMPLE_Z
        |=> dq_oe_n_out) // [RQ16]
        else $error("sample-z left data bus driven");
    bypass_clr_a: assert property (tck_rise
        && state_r == sstp_pkg::ST_CAP_DR
        |=> !byp_r) // [RQ17]
        else $error("bypass bit not cleared");
    tap_walk_a: assert property (tck_rise && pin_lvl[1]
        && state_r == sstp_pkg::ST_SH_DR
        |=> state_r == sstp_pkg::ST_EX1_DR ##1
            state_r == sstp_pkg::ST_EX1_DR) // [RQ18]
        else $error("shift exit transition wrong");

    id_shift_c:  cover property (tck_fall && state_r == sstp_pkg::ST_SH_DR
        && ir_cur_r == sstp_pkg::INS_IDCODE);
    extest_c:    cover property (extest_out && !dq_oe_n_out);
    samplez_c:   cover property (ir_cur_r == sstp_pkg::INS_SAMPLE_Z);
    bypass_c:    cover property (tck_rise && state_r == sstp_pkg::ST_SH_DR
        && ir_cur_r == sstp_pkg::INS_BYPASS);
endmodule

/* dv/sstp_scan_ctrl.sv */
`timescale 1ns/1ns
// Board scan controller model; tck idles low between steps
module sstp_scan_ctrl (
    input  wire logic sys_clk_in,
    input  wire logic tdo_in,
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out
);
    // Idle pin levels at time zero
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // One 80 ns tck period; tdo read just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge sys_clk_in);
        tms_out = m;
        tdi_out = d;
        repeat (5) @(negedge sys_clk_in);
        q = tdo_in;
        tck_out = 1'b1;
        repeat (10) @(negedge sys_clk_in);
        tck_out = 1'b0;
        tdi_out = ~d; // Released data line shows the inverse
        repeat (4) @(negedge sys_clk_in);
    endtask
    // Idle to shift state, n bits, update, back to idle
    task automatic scan(input logic ir, input int n,
                        input logic [108:0] din, output logic [108:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule

/* dv/sram_scan_test_port_test.sv */
`timescale 1ns/1ns
// Top bench: scan controller model against the test port
module sram_scan_test_port_test;
    logic         sys_clk_in = 1'b0;
    logic         rst_n_in   = 1'b0;
    logic         tck, tms, tdi, tdo, tdo_oe_n, dq_oe_n, extest, q;
    logic [107:0] pins       = '0;
    logic [108:0] upd, din, dout, model_upd;
    logic [2:0]   instr;
    logic [31:0]  lfsr_r     = 32'hB1D36B32;
    logic [31:0]  id;
    int           err_count  = 0;
    int           num_checks = 0;
    int           codes[6]   = '{1, 4, 0, 0, 2, 7}; // no reserved
    // System clock, 4 ns period
    always #2 sys_clk_in = ~sys_clk_in;
    sstp_top #(.DENSITY_MB(72), .DATA_WIDTH(18), .RL_HALF(5),
        .BURST_LEN(4), .ODT_PRESENT(1'b1)) u_sstp_top (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .bs_pins_in(pins), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n),
        .bs_update_out(upd), .dq_oe_n_out(dq_oe_n),
        .extest_out(extest), .instr_out(instr));
    sstp_scan_ctrl u_sstp_scan_ctrl (.sys_clk_in(sys_clk_in),
        .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
    // Next random word
    function automatic logic [31:0] rnd();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1]
                  ^ lfsr_r[0]};
        return lfsr_r;
    endfunction
    // Compare and count
    task automatic chk(input logic [108:0] got, input logic [108:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Print counts and verdict, end the run
    task automatic conclude();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog well beyond the expected 62 us
    initial begin
        #200000;
        err_count++;
        conclude();
    end
    // Main sequence
    initial begin
        id = 32'h1;
        id[31:29] = 3'h1;
        id[11:1] = 11'h2A5;
        id[26:24] = sstp_pkg::DEN_72MB;
        id[22:21] = sstp_pkg::WID_X18;
        id[27] = 1'b1;
        id[19:13] = 7'h6E; // One, enhanced, latency, burst, termination
        model_upd = '0;
        repeat (16) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        chk(instr, sstp_pkg::IR_RST);
        // Leave test-logic-reset for idle before the first scan
        u_sstp_scan_ctrl.step(1'b0, 1'b0, q);
        u_sstp_scan_ctrl.scan(1'b0, 32, '0, dout);
        chk(dout[31:16], id[31:16]);
        chk(dout[15:0], id[15:0]);
        foreach (codes[i]) begin
            u_sstp_scan_ctrl.scan(1'b1, 3, 109'(codes[i]), dout);
            chk(instr, 109'(codes[i]));
            chk(extest, codes[i] == 0);
            pins = 108'({rnd(), rnd(), rnd(), rnd()});
            din = {~i[0], pins ^ 108'({rnd(), rnd(), rnd(), rnd()})};
            u_sstp_scan_ctrl.scan(1'b0, 109, din, dout);
            if (codes[i] == 1) begin
                chk(dout[31:0], id);
            end else if (codes[i] == 7) begin
                chk(dout[7:0], {din[6:0], 1'b0});
            end else begin
                chk(dout, {model_upd[108], pins});
                model_upd = din;
            end
            chk(upd, model_upd);
            chk(tdo_oe_n, 1'b1);
            chk(dq_oe_n, codes[i] == 2
                || (codes[i] == 0 && !din[108]));
        end
        repeat (5) u_sstp_scan_ctrl.step(1'b1, 1'b0, q);
        chk(instr, sstp_pkg::IR_RST);
        chk(upd[108], 1'b0);
        conclude();
    end
endmodule
